/* File: hdl/rfc_pkg.sv */
/*
  Package for the receive/transmit mode control block: register indices,
  field positions, reset values, codes and the carrier structs.
  Assumes an AXI4-Lite master with 12-bit byte addresses, 32-bit data.
*/
package rfc_pkg;
  localparam int RFC_AW = 12;
  // Register indices; byte address is four times the index
  localparam logic [7:0] RFC_RXMODE_IDX = 8'h13;
  localparam logic [7:0] RFC_TXCTRL_IDX = 8'h14;
  localparam logic [7:0] RFC_TXASK_IDX = 8'h15;
  localparam logic [7:0] RFC_TXSEL_IDX = 8'h16;
  localparam logic [7:0] RFC_STATUS_IDX = 8'h30;
  localparam logic [7:0] RFC_RXMODE_RST = 8'h00;
  localparam logic [7:0] RFC_TXCTRL_RST = 8'h80;
  localparam logic [7:0] RFC_TXASK_RST = 8'h00;
  localparam logic [7:0] RFC_TXSEL_RST = 8'h10;
  // Writable bits; the rest are reserved and read zero
  localparam logic [7:0] RFC_RXMODE_MASK = 8'hFC;
  localparam logic [7:0] RFC_TXCTRL_MASK = 8'hFB;
  localparam logic [7:0] RFC_TXASK_MASK = 8'h40;
  localparam logic [7:0] RFC_TXSEL_MASK = 8'h3F;
  localparam int RXM_CRC = 7;
  localparam int RXM_RATE_LSB = 4;
  localparam int RXM_SHORT = 3;
  localparam int RXM_MULTI = 2;
  localparam int TXC_INV2_ON = 7;
  localparam int TXC_INV1_ON = 6;
  localparam int TXC_INV2_OFF = 5;
  localparam int TXC_INV1_OFF = 4;
  localparam int TXC_CW2 = 3;
  localparam int TXC_EN2 = 1;
  localparam int TXC_EN1 = 0;
  localparam int ASK_FULL = 6;
  localparam int SEL_DRV_LSB = 4;
  localparam int SEL_AUX_LSB = 0;
  localparam logic [2:0] RATE_106 = 3'h0;
  localparam logic [2:0] RATE_848 = 3'h3;
  localparam int MIN_FRAME_BITS = 4;
  localparam logic [1:0] DRV_HIZ = 2'h0;
  localparam logic [1:0] DRV_MILLER = 2'h1;
  localparam logic [1:0] DRV_AUXIN = 2'h2;
  localparam logic [1:0] DRV_HIGH = 2'h3;
  localparam logic [3:0] AUX_HIZ = 4'h0;
  localparam logic [3:0] AUX_LOW = 4'h1;
  localparam logic [3:0] AUX_HIGH = 4'h2;
  localparam logic [3:0] AUX_TEST = 4'h3;
  localparam logic [3:0] AUX_MILLER = 4'h4;
  localparam logic [3:0] AUX_TXSER = 4'h5;
  localparam logic [3:0] AUX_RXDEC = 4'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {RX_IDLE, RX_ON} rfc_rx_t;

  typedef struct packed {
    logic awvalid;
    logic [RFC_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [RFC_AW-1:0] araddr;
    logic rready;
  } rfc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rfc_axi_rsp_t;

  typedef struct packed {
    rfc_axi_rsp_t bus;
    logic awHave;
    logic [RFC_AW-1:0] awAddr;
    logic wHave;
    logic [7:0] wData;
    logic wLane0;
    logic [7:0] rxMode;
    logic [7:0] txCtrl;
    logic [7:0] txAsk;
    logic [7:0] txSel;
    rfc_rx_t rxSt;
    logic discard;
    logic done;
    logic pushValid;
    logic [7:0] pushData;
    logic [2:0] sync;
    logic auxIn;
    logic drv1;
    logic drv2;
    logic drvHiZ;
    logic auxOut;
    logic auxHiZ;
  } rfc_state_t;
endpackage : rfc_pkg

/* File: hdl/rfc_mode_ctrl.sv */
/*
  Receive/transmit mode control: AXI4-Lite register slave, receiver on/off
  sequencing with multi-frame error byte, antenna driver and aux output logic.
  Assumes the frame decoder, command engine and encoder share clk; only the
  aux serial input pin arrives asynchronously.
*/
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns

module rfc_mode_ctrl #(
  parameter int FRAME_BITS_W = 8,
  parameter logic [3:0] RX_CMD = 4'h1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire rfc_pkg::rfc_axi_req_t axiReq,
  output rfc_pkg::rfc_axi_rsp_t axiRsp,
  input wire logic cmdWrite,
  input wire logic [3:0] cmdCode,
  input wire logic rxArm,
  input wire logic rxFrameEnd,
  input wire logic [FRAME_BITS_W-1:0] rxFrameBits,
  input wire logic [7:0] errorRegValue,
  input wire logic millerEnvelope,
  input wire logic txSerialData,
  input wire logic rxDecodedData,
  input wire logic testBusBit,
  input wire logic auxSerialIn,
  output logic receiveActive,
  output logic receiveCrcCheckOn,
  output logic [2:0] receiveBitRate,
  output logic shortFrameDropped,
  output logic receiveDone,
  output logic fifoPushValid,
  output logic [7:0] fifoPushData,
  output logic forceFullAsk,
  output logic antennaDriveOne,
  output logic antennaDriveTwo,
  output logic antennaDriveHiZ,
  output logic auxSerialOut,
  output logic auxSerialOutHiZ
);
  import rfc_pkg::*;

  initial begin
    if (FRAME_BITS_W < 3) begin
      $error("FRAME_BITS_W too small to count a short frame");
    end
  end

  localparam rfc_state_t RST_STATE = '{
    rxMode: RFC_RXMODE_RST,
    txCtrl: RFC_TXCTRL_RST,
    txAsk: RFC_TXASK_RST,
    txSel: RFC_TXSEL_RST,
    rxSt: RX_IDLE,
    drvHiZ: 1'b0,
    auxHiZ: 1'b1,
    default: '0
  };

  rfc_state_t r;
  rfc_state_t rNxt;
  logic isShort;
  logic stopCmd;
  logic wrGo;
  logic [7:0] wrIdx;
  logic wrMapped;
  logic [7:0] rdIdx;
  logic [7:0] rdVal;
  logic [1:0] drvSel;
  logic env;

  assign isShort = rxFrameBits < FRAME_BITS_W'(MIN_FRAME_BITS);
  assign stopCmd = cmdWrite && (cmdCode != RX_CMD);
  assign drvSel = r.txSel[SEL_DRV_LSB +: 2];

  always_comb begin
    rNxt = r;
    rNxt.discard = 1'b0;
    rNxt.done = 1'b0;
    rNxt.pushValid = 1'b0;
    // Bus write: address and data may come in either order
    if (axiReq.awvalid && r.bus.awready) begin
      rNxt.awHave = 1'b1;
      rNxt.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && r.bus.wready) begin
      rNxt.wHave = 1'b1;
      rNxt.wData = axiReq.wdata[7:0];
      rNxt.wLane0 = axiReq.wstrb[0];
    end
    if (r.bus.bvalid && axiReq.bready) begin
      rNxt.bus.bvalid = 1'b0;
    end
    wrGo = r.awHave && r.wHave && !r.bus.bvalid;
    wrIdx = r.awAddr[9:2];
    wrMapped = (r.awAddr[RFC_AW-1:10] == '0) && (wrIdx == RFC_RXMODE_IDX
      || wrIdx == RFC_TXCTRL_IDX || wrIdx == RFC_TXASK_IDX
      || wrIdx == RFC_TXSEL_IDX || wrIdx == RFC_STATUS_IDX);
    if (wrGo) begin
      rNxt.awHave = 1'b0;
      rNxt.wHave = 1'b0;
      rNxt.bus.bvalid = 1'b1;
      rNxt.bus.bresp = wrMapped ? RESP_OKAY : RESP_SLVERR;
      if (r.wLane0) begin
        if (wrIdx == RFC_RXMODE_IDX && wrMapped) begin
          rNxt.rxMode = r.wData & RFC_RXMODE_MASK;
          if (r.wData[RXM_RATE_LSB +: 3] > RATE_848) begin
            rNxt.rxMode[RXM_RATE_LSB +: 3] = r.rxMode[RXM_RATE_LSB +: 3];
          end
          if (!r.wData[RXM_CRC] && rNxt.rxMode[RXM_RATE_LSB +: 3] != RATE_106) begin
            rNxt.rxMode[RXM_CRC] = r.rxMode[RXM_CRC];
          end
        end
        if (wrIdx == RFC_TXCTRL_IDX && wrMapped) begin
          rNxt.txCtrl = r.wData & RFC_TXCTRL_MASK;
        end
        if (wrIdx == RFC_TXASK_IDX && wrMapped) begin
          rNxt.txAsk = r.wData & RFC_TXASK_MASK;
        end
        if (wrIdx == RFC_TXSEL_IDX && wrMapped) begin
          rNxt.txSel = r.wData & RFC_TXSEL_MASK;
        end
      end
    end
    // Ready drops while a half is held so a second write cannot overrun it
    rNxt.bus.awready = !rNxt.awHave && !rNxt.bus.bvalid;
    rNxt.bus.wready = !rNxt.wHave && !rNxt.bus.bvalid;

    // Bus read
    rdIdx = axiReq.araddr[9:2];
    rdVal = 8'h00;
    if (axiReq.araddr[RFC_AW-1:10] == '0) begin
      unique case (rdIdx)
        RFC_RXMODE_IDX: rdVal = r.rxMode;
        RFC_TXCTRL_IDX: rdVal = r.txCtrl;
        RFC_TXASK_IDX: rdVal = r.txAsk;
        RFC_TXSEL_IDX: rdVal = r.txSel;
        RFC_STATUS_IDX: rdVal = {6'h00, r.auxIn, r.rxSt == RX_ON};
        default: rdVal = 8'h00;
      endcase
    end
    if (r.bus.rvalid && axiReq.rready) begin
      rNxt.bus.rvalid = 1'b0;
    end
    if (axiReq.arvalid && r.bus.arready) begin
      rNxt.bus.rvalid = 1'b1;
      rNxt.bus.rdata = {24'h000000, rdVal};
      rNxt.bus.rresp = (axiReq.araddr[RFC_AW-1:10] == '0 && (rdIdx == RFC_RXMODE_IDX
        || rdIdx == RFC_TXCTRL_IDX || rdIdx == RFC_TXASK_IDX
        || rdIdx == RFC_TXSEL_IDX || rdIdx == RFC_STATUS_IDX)) ? RESP_OKAY : RESP_SLVERR;
    end
    rNxt.bus.arready = !rNxt.bus.rvalid;

    // Receiver sequencing
    unique case (r.rxSt)
      RX_IDLE: begin
        if (rxArm) begin
          rNxt.rxSt = RX_ON;
        end
      end
      RX_ON: begin
        if (rxFrameEnd) begin
          if (r.rxMode[RXM_SHORT] && isShort) begin
            rNxt.discard = 1'b1;
          end else if (r.rxMode[RXM_MULTI]) begin
            rNxt.pushValid = 1'b1;
            rNxt.pushData = errorRegValue;
            rNxt.rxSt = RX_ON;
          end else begin
            rNxt.done = 1'b1;
            rNxt.rxSt = RX_IDLE;
          end
        end
        // stop by command or bit clear
        if (stopCmd || (r.rxMode[RXM_MULTI] && !rNxt.rxMode[RXM_MULTI])) begin
          rNxt.rxSt = RX_IDLE;
        end
        if (rxArm) begin
          rNxt.rxSt = RX_ON;
        end
      end
    endcase

    // Aux pin: the third stage is taken only when the second agrees with it, the first feeds the second alone
    rNxt.sync = {r.sync[1:0], auxSerialIn};
    if (r.sync[1] == r.sync[2]) begin
      rNxt.auxIn = r.sync[2];
    end

    unique case (drvSel)
      DRV_MILLER: env = millerEnvelope;
      DRV_AUXIN: env = r.auxIn;
      DRV_HIGH: env = 1'b1;
      DRV_HIZ: env = 1'b0;
    endcase
    rNxt.drvHiZ = (drvSel == DRV_HIZ);
    rNxt.drv1 = r.txCtrl[TXC_EN1] ? (env ^ r.txCtrl[TXC_INV1_ON]) : r.txCtrl[TXC_INV1_OFF];
    rNxt.drv2 = r.txCtrl[TXC_EN2]
      ? ((r.txCtrl[TXC_CW2] | env) ^ r.txCtrl[TXC_INV2_ON]) : r.txCtrl[TXC_INV2_OFF];

    rNxt.auxHiZ = 1'b0;
    unique case (r.txSel[SEL_AUX_LSB +: 4])
      AUX_LOW: rNxt.auxOut = 1'b0;
      AUX_HIGH: rNxt.auxOut = 1'b1;
      AUX_TEST: rNxt.auxOut = testBusBit;
      AUX_MILLER: rNxt.auxOut = millerEnvelope;
      AUX_TXSER: rNxt.auxOut = txSerialData;
      AUX_RXDEC: rNxt.auxOut = rxDecodedData;
      default: begin
        // The three-state code and reserved codes float the pin
        rNxt.auxOut = 1'b0;
        rNxt.auxHiZ = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= RST_STATE;
    end else begin
      r <= rNxt;
    end
  end

  assign axiRsp = r.bus;
  assign receiveActive = (r.rxSt == RX_ON);
  assign receiveCrcCheckOn = r.rxMode[RXM_CRC];
  assign receiveBitRate = r.rxMode[RXM_RATE_LSB +: 3];
  assign shortFrameDropped = r.discard;
  assign receiveDone = r.done;
  assign fifoPushValid = r.pushValid;
  assign fifoPushData = r.pushData;
  assign forceFullAsk = r.txAsk[ASK_FULL];
  assign antennaDriveOne = r.drv1;
  assign antennaDriveTwo = r.drv2;
  assign antennaDriveHiZ = r.drvHiZ;
  assign auxSerialOut = r.auxOut;
  assign auxSerialOutHiZ = r.auxHiZ;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence frameSeen;
    r.rxSt == RX_ON && rxFrameEnd && !rxArm && !cmdWrite && !wrGo;
  endsequence
  sequence frameKept;
    frameSeen and !(r.rxMode[RXM_SHORT] && isShort);
  endsequence

  AST_CRC_CLEAR: assert property (
    $fell(r.rxMode[RXM_CRC]) |-> r.rxMode[RXM_RATE_LSB +: 3] == RATE_106)
    else $error("CRC check cleared away from 106 kBd");
  AST_RATE_LEGAL: assert property (
    receiveBitRate <= RATE_848) else $error("Reserved rate stored");
  AST_SHORT_DROP: assert property (
    frameSeen and (r.rxMode[RXM_SHORT] && isShort) |=> shortFrameDropped && receiveActive)
    else $error("Short frame not dropped");
  AST_SINGLE_END: assert property (
    frameKept and !r.rxMode[RXM_MULTI] |=> receiveDone && !receiveActive)
    else $error("Receiver stayed on after single frame");
  AST_MULTI_STAY: assert property (
    frameKept and r.rxMode[RXM_MULTI] && !wrGo |=> receiveActive && !receiveDone)
    else $error("Multi-frame reception ended by itself");
  AST_STOP_CMD: assert property (
    receiveActive && stopCmd && !rxArm |=> !receiveActive)
    else $error("Non-receive command did not stop receiver");
  AST_ERR_BYTE: assert property (
    frameKept and r.rxMode[RXM_MULTI] |=> fifoPushValid && fifoPushData == $past(errorRegValue))
    else $error("Error byte missing or wrong");
  AST_DRV1_ON: assert property (
    r.txCtrl[TXC_EN1] && drvSel == DRV_HIGH |=> antennaDriveOne == !$past(r.txCtrl[TXC_INV1_ON]))
    else $error("Driver one inversion wrong while on");
  AST_DRV2_OFF: assert property (
    !r.txCtrl[TXC_EN2] |=> antennaDriveTwo == $past(r.txCtrl[TXC_INV2_OFF]))
    else $error("Driver two level wrong while off");
  AST_CW2: assert property (
    r.txCtrl[TXC_EN2] && r.txCtrl[TXC_CW2] |=> antennaDriveTwo == !$past(r.txCtrl[TXC_INV2_ON]))
    else $error("Driver two not unmodulated");
  AST_DRV_HIZ: assert property (
    drvSel == DRV_HIZ |=> antennaDriveHiZ) else $error("Drivers not three-state");
  AST_AUX_LOW: assert property (
    r.txSel[3:0] == AUX_LOW |=> !auxSerialOutHiZ && !auxSerialOut)
    else $error("Aux output not low");
  AST_RESV_ZERO: assert property (
    (r.txCtrl & ~RFC_TXCTRL_MASK) == 8'h00 && (r.txSel & ~RFC_TXSEL_MASK) == 8'h00)
    else $error("Reserved bit set");

  // Accepted writes to a given register, used by the layout checks
  sequence askWrite;
    wrGo && r.wLane0 && wrMapped && wrIdx == RFC_TXASK_IDX;
  endsequence
  sequence selWrite;
    wrGo && r.wLane0 && wrMapped && wrIdx == RFC_TXSEL_IDX;
  endsequence

  AST_DRV2_ON: assert property (
    r.txCtrl[TXC_EN2] && !r.txCtrl[TXC_CW2] && drvSel == DRV_HIGH
      |=> antennaDriveTwo == !$past(r.txCtrl[TXC_INV2_ON]))
    else $error("Driver two inversion wrong while on");
  AST_DRV1_OFF: assert property (
    !r.txCtrl[TXC_EN1] |=> antennaDriveOne == $past(r.txCtrl[TXC_INV1_OFF]))
    else $error("Driver one level wrong while off");
  AST_DRV1_MOD: assert property (
    r.txCtrl[TXC_EN1] && drvSel == DRV_MILLER
      |=> antennaDriveOne == ($past(millerEnvelope) ^ $past(r.txCtrl[TXC_INV1_ON])))
    else $error("Driver one does not follow the envelope");
  AST_FULL_ASK: assert property (
    askWrite |=> forceFullAsk == $past(r.wData[ASK_FULL]))
    else $error("Full ASK bit not taken from write");
  AST_RESET_VAL: assert property (
    $rose(reset_n) |-> r.txCtrl == RFC_TXCTRL_RST && r.txSel == RFC_TXSEL_RST
      && !receiveActive)
    else $error("Register reset value wrong");
  AST_SEL_LAYOUT: assert property (
    selWrite |=> drvSel == $past(r.wData[SEL_DRV_LSB +: 2])
      && r.txSel[SEL_AUX_LSB +: 4] == $past(r.wData[SEL_AUX_LSB +: 4]))
    else $error("Source select fields misplaced");
endmodule : rfc_mode_ctrl

/* File: tb/rfc_card_model.sv */
/*
  Card side model: ends received streams with a bit count and drives the
  aux serial input pin. Assumes the bench calls its tasks after a clock edge.
*/
`timescale 1ns/1ns
module rfc_card_model (
  input wire logic clk,
  output logic frameEnd,
  output logic [7:0] frameBits,
  output logic auxPin
);
  initial begin
    frameEnd = 1'b0;
    frameBits = 8'hA5;
    auxPin = 1'b0;
  end

  // Count is only valid with the end pulse; it flips afterwards so stale use shows
  task automatic reply(input logic [7:0] n);
    @(posedge clk);
    frameEnd <= 1'b1;
    frameBits <= n;
    @(posedge clk);
    frameEnd <= 1'b0;
    frameBits <= ~n;
  endtask : reply

  task automatic setPin(input logic v);
    @(posedge clk);
    auxPin <= v;
  endtask : setPin
endmodule : rfc_card_model

/* File: tb/rfc_mode_ctrl_bench.sv */
/*
  Self-checking bench for rfc_mode_ctrl: registers, receiver, drivers, aux.
  Assumes the card model drives frame ends and the aux pin.
*/
`timescale 1ns/1ns
module rfc_mode_ctrl_bench;
  import rfc_pkg::*;
  localparam logic [3:0] RX_CODE = 4'h1;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  rfc_axi_req_t req = '0;
  rfc_axi_rsp_t rsp;
  logic cmdWrite = 1'b0;
  logic [3:0] cmdCode = 4'h0;
  logic rxArm = 1'b0;
  logic [7:0] errVal = 8'h00;
  logic miller = 1'b0;
  logic txSer = 1'b0;
  logic rxDec = 1'b0;
  logic testBit = 1'b0;
  logic frameEnd, pin, act, crcOn, drop, done, push, ask, d1, d2, dHiZ, aOut, aHiZ;
  logic [7:0] frameBits, pushData, seenPush;
  logic [2:0] rate;
  int n_fail = 0;
  int comparisons = 0;

  always #25 clk = ~clk;

  rfc_mode_ctrl #(.FRAME_BITS_W(8), .RX_CMD(RX_CODE)) i_rfc_mode_ctrl (
    .clk(clk), .reset_n(reset_n), .axiReq(req), .axiRsp(rsp), .cmdWrite(cmdWrite),
    .cmdCode(cmdCode), .rxArm(rxArm), .rxFrameEnd(frameEnd), .rxFrameBits(frameBits),
    .errorRegValue(errVal), .millerEnvelope(miller), .txSerialData(txSer),
    .rxDecodedData(rxDec), .testBusBit(testBit), .auxSerialIn(pin), .receiveActive(act),
    .receiveCrcCheckOn(crcOn), .receiveBitRate(rate), .shortFrameDropped(drop),
    .receiveDone(done), .fifoPushValid(push), .fifoPushData(pushData),
    .forceFullAsk(ask), .antennaDriveOne(d1), .antennaDriveTwo(d2),
    .antennaDriveHiZ(dHiZ), .auxSerialOut(aOut), .auxSerialOutHiZ(aHiZ));

  rfc_card_model i_rfc_card_model (.clk(clk), .frameEnd(frameEnd), .frameBits(frameBits),
    .auxPin(pin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // Both halves offered together; each is dropped at its own ready
  task automatic axiWr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge clk);
    req.awaddr <= {2'h0, idx, 2'h0};
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!got && n < 50) begin
      @(posedge clk);
      n++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        got = 1'b1;
        req.bready <= 1'b0;
        check({30'h0, rsp.bresp}, {30'h0, er});
      end
    end
    if (!got) begin
      check(32'h0, 32'h1);
      summarize();
    end
  endtask : axiWr

  task automatic axiRd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge clk);
    req.araddr <= {2'h0, idx, 2'h0};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    while (!got && n < 50) begin
      @(posedge clk);
      n++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        got = 1'b1;
        req.rready <= 1'b0;
        check(rsp.rdata, {24'h0, d});
        check({30'h0, rsp.rresp}, {30'h0, er});
      end
    end
    if (!got) begin
      check(32'h0, 32'h1);
      summarize();
    end
  endtask : axiRd

  task automatic pulse(input logic arm, input logic [3:0] c);
    @(posedge clk);
    rxArm <= arm;
    cmdWrite <= !arm;
    cmdCode <= c;
    @(posedge clk);
    rxArm <= 1'b0;
    cmdWrite <= 1'b0;
    repeat (2) @(negedge clk);
  endtask : pulse

  // Expected is {dropped, done, push, still active}
  task automatic frame(input logic [7:0] bits, input logic [3:0] e);
    logic [2:0] s;
    i_rfc_card_model.reply(bits);
    @(negedge clk);
    s = {drop, done, push};
    seenPush = pushData;
    @(negedge clk);
    check(32'({s, act}), 32'(e));
  endtask : frame

  task automatic testRegs();
    axiRd(RFC_TXCTRL_IDX, 8'h80, RESP_OKAY);
    axiRd(RFC_TXSEL_IDX, 8'h10, RESP_OKAY);
    axiRd(RFC_TXASK_IDX, 8'h00, RESP_OKAY);
    @(negedge clk);
    check(32'({act, ask, dHiZ, d1, d2}), 32'h0);
    axiRd(8'h20, 8'h00, RESP_SLVERR);
    axiWr(8'h21, 8'h55, RESP_SLVERR);
    axiWr(RFC_STATUS_IDX, 8'hFF, RESP_OKAY);
    axiRd(RFC_STATUS_IDX, 8'h00, RESP_OKAY);
    axiWr(RFC_TXCTRL_IDX, 8'hFF, RESP_OKAY);
    axiRd(RFC_TXCTRL_IDX, 8'hFB, RESP_OKAY);
    axiWr(RFC_TXSEL_IDX, 8'hFF, RESP_OKAY);
    axiRd(RFC_TXSEL_IDX, 8'h3F, RESP_OKAY);
    axiWr(RFC_TXASK_IDX, 8'hFF, RESP_OKAY);
    axiRd(RFC_TXASK_IDX, 8'h40, RESP_OKAY);
    @(negedge clk);
    check(32'(ask), 32'h1);
    axiWr(RFC_TXASK_IDX, 8'h00, RESP_OKAY);
    @(negedge clk);
    check(32'(ask), 32'h0);
    $display("registers done");
  endtask : testRegs

  task automatic testRate();
    logic [2:0] prev;
    prev = RATE_106;
    for (int r = 0; r < 8; r++) begin
      axiWr(RFC_RXMODE_IDX, {1'b1, r[2:0], 4'h0}, RESP_OKAY);
      prev = (r < 4) ? r[2:0] : prev;
      @(negedge clk);
      check(32'({crcOn, rate}), 32'({1'b1, prev}));
    end
    axiWr(RFC_RXMODE_IDX, 8'h30, RESP_OKAY);
    axiRd(RFC_RXMODE_IDX, 8'hB0, RESP_OKAY);
    axiWr(RFC_RXMODE_IDX, 8'h03, RESP_OKAY);
    axiRd(RFC_RXMODE_IDX, 8'h00, RESP_OKAY);
    $display("rate done");
  endtask : testRate

  task automatic testRx();
    pulse(1'b1, 4'h0);
    frame(8'h08, 4'b0100);
    frame(8'h08, 4'b0000);
    axiWr(RFC_RXMODE_IDX, 8'h08, RESP_OKAY);
    pulse(1'b1, 4'h0);
    frame(8'h03, 4'b1001);
    frame(8'h04, 4'b0100);
    axiWr(RFC_RXMODE_IDX, 8'h14, RESP_OKAY);
    errVal <= 8'h5A;
    pulse(1'b1, 4'h0);
    axiRd(RFC_STATUS_IDX, 8'h01, RESP_OKAY);
    frame(8'h02, 4'b0011);
    check(32'(seenPush), 32'h5A);
    @(posedge clk);
    errVal <= 8'hC3;
    frame(8'hFF, 4'b0011);
    check(32'(seenPush), 32'hC3);
    pulse(1'b0, RX_CODE);
    check(32'(act), 32'h1);
    pulse(1'b0, 4'hC);
    check(32'(act), 32'h0);
    pulse(1'b1, 4'h0);
    check(32'(act), 32'h1);
    axiWr(RFC_RXMODE_IDX, 8'h10, RESP_OKAY);
    @(negedge clk);
    check(32'(act), 32'h0);
    $display("receiver done");
  endtask : testRx

  task automatic testDrv();
    logic [7:0] tab [7] = '{8'h00, 8'hF0, 8'h20, 8'hC3, 8'h33, 8'hCB, 8'h89};
    logic [7:0] c;
    logic env;
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      miller <= p[0];
      i_rfc_card_model.setPin(!p[0]);
      repeat (8) @(posedge clk);
      for (int s = 0; s < 4; s++) begin
        for (int i = 0; i < 7; i++) begin
          c = tab[i];
          axiWr(RFC_TXCTRL_IDX, c, RESP_OKAY);
          axiWr(RFC_TXSEL_IDX, {2'h0, s[1:0], 4'h0}, RESP_OKAY);
          env = (s == 3) || (s == 1 && p == 1) || (s == 2 && p == 0);
          repeat (2) @(negedge clk);
          check(32'({d1, d2, dHiZ}), 32'({c[0] ? env ^ c[6] : c[4],
            c[1] ? (c[3] | env) ^ c[7] : c[5], s == 0}));
        end
      end
    end
    $display("drivers done");
  endtask : testDrv

  task automatic testAux();
    logic eo;
    logic hz;
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      testBit <= p[0];
      miller <= !p[0];
      txSer <= p[0];
      rxDec <= !p[0];
      for (int k = 0; k < 16; k++) begin
        axiWr(RFC_TXSEL_IDX, {4'h0, k[3:0]}, RESP_OKAY);
        eo = (k == 2) || ((k == 3 || k == 5) && p == 1) || ((k == 4 || k == 7) && p == 0);
        hz = !(k inside {1, 2, 3, 4, 5, 7});
        repeat (2) @(negedge clk);
        check(32'({aHiZ, hz ? 1'b0 : aOut}), 32'({hz, eo}));
      end
    end
    $display("aux done");
  endtask : testAux

  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    testRegs();
    testRate();
    testRx();
    testDrv();
    testAux();
    summarize();
  end
endmodule : rfc_mode_ctrl_bench
